// ==== logic/psc_top.sv ====
// Proximity sensor controller: I2C slave, register file, sequencer, threshold filter
`timescale 1ns/10ps
`default_nettype none
module psc_top #(
  parameter logic [6:0] SLAVE_ADDR = psc_pkg::ADDR_VARIANT_A,
  parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary value
  parameter int STEP_CYCLES = psc_pkg::STEP_CYC,
  parameter int PULSE_CYCLES = psc_pkg::PULSE_CYC
) (
  input wire logic mclk, // 25 MHz core clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic scl_in, // Bus clock from host
  input wire logic sda_in, // Bus data level
  output logic sda_out, // Data drive value, always low
  output logic sda_oe, // High while pulling data low
  output logic irq_n, // Interrupt, active low
  output logic led_pulse, // LED sink pulse request
  output logic [1:0] led_current_select, // Sink current level
  output logic [1:0] photodiode_select, // Diode feeding measurement
  output logic adc_start, // One-cycle conversion start
  input wire logic adc_done, // Converter finished
  input wire logic [15:0] adc_value // Converter result
);
  logic [7:0] enable_ff, integration_duration_ff, wait_duration_ff, event_persistence_ff, config_ff, pulse_ff, control_ff;
  psc_pkg::psc_limits_s lim_ff;
  logic [15:0] result_ff;
  logic [7:0] cmd_ff;
  logic irq_pend_ff, prox_valid_ff;
  logic [3:0] event_persistence_cnt_ff;
  logic [2:0] scl_sync_ff, sda_sync_ff;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  // Bus deframing
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
    end
  end
  assign scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
  assign scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
  assign bus_start = scl_sync_ff[1] & sda_sync_ff[2] & ~sda_sync_ff[1];
  assign bus_stop = scl_sync_ff[1] & ~sda_sync_ff[2] & sda_sync_ff[1];

  psc_pkg::psc_bus_e bus_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_ff;
  logic rd_ff, first_ff, nack_ff;
  logic wr_strobe, sf_clear;
  logic [7:0] rd_data;
  always_comb
  begin
    case (cmd_ff[4:0])
      psc_pkg::REG_ENABLE: rd_data = enable_ff;
      psc_pkg::REG_INTEG_TIME: rd_data = integration_duration_ff;
      psc_pkg::REG_WAIT_TIME: rd_data = wait_duration_ff;
      psc_pkg::REG_LOW_L: rd_data = lim_ff.low[7:0];
      psc_pkg::REG_LOW_H: rd_data = lim_ff.low[15:8];
      psc_pkg::REG_HIGH_L: rd_data = lim_ff.high[7:0];
      psc_pkg::REG_HIGH_H: rd_data = lim_ff.high[15:8];
      psc_pkg::REG_PERSIST: rd_data = event_persistence_ff;
      psc_pkg::REG_CONFIG: rd_data = config_ff;
      psc_pkg::REG_PULSE: rd_data = pulse_ff;
      psc_pkg::REG_CONTROL: rd_data = control_ff;
      psc_pkg::REG_ID: rd_data = PART_ID;
      psc_pkg::REG_STATUS: rd_data = {2'b00, irq_pend_ff, 4'h0, prox_valid_ff};
      psc_pkg::REG_RES_L: rd_data = result_ff[7:0];
      psc_pkg::REG_RES_H: rd_data = result_ff[15:8];
      default: rd_data = 8'h00;
    endcase
  end
  // Data byte complete during write phase
  assign wr_strobe = (bus_ff == psc_pkg::BUS_WBYTE) && scl_fall && bit_ff == 4'd8
    && !(first_ff && shift_ff[7]);
  assign sf_clear = (bus_ff == psc_pkg::BUS_WBYTE) && scl_fall && bit_ff == 4'd8
    && first_ff && shift_ff[7] && shift_ff[6:5] == psc_pkg::TYPE_SPECIAL
    && shift_ff[4:0] == psc_pkg::SF_IRQ_CLEAR;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bus_ff <= psc_pkg::BUS_IDLE;
      shift_ff <= 8'h00;
      bit_ff <= 4'h0;
      rd_ff <= 1'b0;
      first_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (bus_start)
    begin
      bus_ff <= psc_pkg::BUS_ADDR;
      bit_ff <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      bus_ff <= psc_pkg::BUS_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (bus_ff)
        psc_pkg::BUS_ADDR:
        begin
          if (scl_rise)
          begin
            shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
            bit_ff <= bit_ff + 4'd1;
          end
          else if (scl_fall && bit_ff == 4'd8)
          begin
            if (shift_ff[7:1] == SLAVE_ADDR)
            begin
              rd_ff <= shift_ff[0];
              first_ff <= ~shift_ff[0];
              sda_oe <= 1'b1;
              bus_ff <= psc_pkg::BUS_AACK;
            end
            else
              bus_ff <= psc_pkg::BUS_IDLE;
          end
        end
        psc_pkg::BUS_AACK, psc_pkg::BUS_WACK:
        begin
          if (scl_fall)
          begin
            bit_ff <= 4'h0;
            if (rd_ff)
            begin
              shift_ff <= rd_data;
              sda_oe <= ~rd_data[7];
              bus_ff <= psc_pkg::BUS_RBYTE;
            end
            else
            begin
              sda_oe <= 1'b0;
              bus_ff <= psc_pkg::BUS_WBYTE;
            end
          end
        end
        psc_pkg::BUS_WBYTE:
        begin
          if (scl_rise)
          begin
            shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
            bit_ff <= bit_ff + 4'd1;
          end
          else if (scl_fall && bit_ff == 4'd8)
          begin
            first_ff <= 1'b0;
            sda_oe <= 1'b1;
            bus_ff <= psc_pkg::BUS_WACK;
          end
        end
        psc_pkg::BUS_RBYTE:
        begin
          if (scl_rise)
          begin
            bit_ff <= bit_ff + 4'd1;
            if (bit_ff == 4'd8)
              nack_ff <= sda_sync_ff[1];
          end
          else if (scl_fall)
          begin
            if (bit_ff == 4'd9)
            begin
              if (nack_ff)
              begin
                sda_oe <= 1'b0;
                bus_ff <= psc_pkg::BUS_IDLE;
              end
              else
              begin
                bit_ff <= 4'h0;
                shift_ff <= rd_data;
                sda_oe <= ~rd_data[7];
              end
            end
            else if (bit_ff == 4'd8)
              sda_oe <= 1'b0;
            else
            begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sda_oe <= ~shift_ff[6];
            end
          end
        end
        default: bus_ff <= psc_pkg::BUS_IDLE;
      endcase
    end
  end
  assign sda_out = 1'b0;

  // Command pointer and auto-increment
  // Incrementing reads step the pointer as each byte is loaded, so the next load sees the next register
  logic data_done;
  assign data_done = wr_strobe || (scl_fall && rd_ff && (bus_ff == psc_pkg::BUS_AACK
    || bus_ff == psc_pkg::BUS_WACK || (bus_ff == psc_pkg::BUS_RBYTE && bit_ff == 4'd9 && !nack_ff)));
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      cmd_ff <= psc_pkg::RST_ZERO;
    else if (bus_ff == psc_pkg::BUS_WBYTE && scl_fall && bit_ff == 4'd8 && first_ff
      && shift_ff[7] && shift_ff[6:5] != psc_pkg::TYPE_SPECIAL)
      cmd_ff <= shift_ff;
    else if (data_done && cmd_ff[6:5] == psc_pkg::TYPE_INCR)
      cmd_ff[4:0] <= cmd_ff[4:0] + 5'd1;
  end

  // Register writes
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      enable_ff <= psc_pkg::RST_ZERO;
      integration_duration_ff <= psc_pkg::RST_TIME;
      wait_duration_ff <= psc_pkg::RST_TIME;
      lim_ff <= '0;
      event_persistence_ff <= psc_pkg::RST_ZERO;
      config_ff <= psc_pkg::RST_ZERO;
      pulse_ff <= psc_pkg::RST_ZERO;
      control_ff <= psc_pkg::RST_ZERO;
    end
    else if (wr_strobe)
    begin
      case (cmd_ff[4:0])
        psc_pkg::REG_ENABLE: enable_ff <= shift_ff & 8'h2F;
        psc_pkg::REG_INTEG_TIME: integration_duration_ff <= shift_ff;
        psc_pkg::REG_WAIT_TIME: wait_duration_ff <= shift_ff;
        psc_pkg::REG_LOW_L: lim_ff.low[7:0] <= shift_ff;
        psc_pkg::REG_LOW_H: lim_ff.low[15:8] <= shift_ff;
        psc_pkg::REG_HIGH_L: lim_ff.high[7:0] <= shift_ff;
        psc_pkg::REG_HIGH_H: lim_ff.high[15:8] <= shift_ff;
        psc_pkg::REG_PERSIST: event_persistence_ff <= shift_ff;
        psc_pkg::REG_CONFIG: config_ff <= shift_ff;
        psc_pkg::REG_PULSE: pulse_ff <= shift_ff;
        psc_pkg::REG_CONTROL: control_ff <= shift_ff;
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      led_current_select <= 2'b00;
      photodiode_select <= 2'b00;
    end
    else
    begin
      led_current_select <= control_ff[7:6];
      photodiode_select <= control_ff[5:4];
    end
  end

  // Sequencer
  psc_pkg::psc_seq_e seq_ff;
  logic [31:0] tmr_ff;
  logic [8:0] steps_ff;
  logic [7:0] pulses_ff;
  logic [3:0] longx_ff;
  logic power_on_bit, prox_function_enable, wait_en;
  assign power_on_bit = enable_ff[psc_pkg::BIT_POWER_ON];
  assign prox_function_enable = enable_ff[2:1] == 2'b11;
  assign wait_en = enable_ff[psc_pkg::BIT_WEN];
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      seq_ff <= psc_pkg::SEQ_SLEEP;
      tmr_ff <= 32'h0;
      steps_ff <= 9'h0;
      pulses_ff <= 8'h00;
      longx_ff <= 4'h0;
      led_pulse <= 1'b0;
      adc_start <= 1'b0;
    end
    else
    begin
      adc_start <= 1'b0;
      led_pulse <= 1'b0;
      case (seq_ff)
        psc_pkg::SEQ_SLEEP:
          if (power_on_bit)
          begin
            tmr_ff <= 32'h0;
            seq_ff <= psc_pkg::SEQ_SDELAY;
          end
        psc_pkg::SEQ_SDELAY:
          if (tmr_ff == 32'(STEP_CYCLES - 1))
            seq_ff <= psc_pkg::SEQ_START;
          else
            tmr_ff <= tmr_ff + 32'h1;
        psc_pkg::SEQ_START:
          if (!power_on_bit)
            seq_ff <= psc_pkg::SEQ_SLEEP;
          else if (prox_function_enable && pulse_ff != 8'h00)
          begin
            tmr_ff <= 32'h0;
            pulses_ff <= pulse_ff;
            seq_ff <= psc_pkg::SEQ_ACCUM;
          end
          else
            seq_ff <= psc_pkg::SEQ_WCHECK;
        psc_pkg::SEQ_ACCUM:
        begin
          led_pulse <= tmr_ff < 32'(PULSE_CYCLES / 2);
          if (tmr_ff == 32'(PULSE_CYCLES - 1))
          begin
            tmr_ff <= 32'h0;
            pulses_ff <= pulses_ff - 8'd1;
            if (pulses_ff == 8'd1)
            begin
              adc_start <= 1'b1;
              steps_ff <= 9'h100 - {1'b0, integration_duration_ff};
              seq_ff <= psc_pkg::SEQ_CONV;
            end
          end
          else
            tmr_ff <= tmr_ff + 32'h1;
        end
        psc_pkg::SEQ_CONV:
          if (adc_done)
            seq_ff <= psc_pkg::SEQ_WCHECK;
        psc_pkg::SEQ_WCHECK:
          if (!power_on_bit)
            seq_ff <= psc_pkg::SEQ_SLEEP;
          else if (wait_en)
          begin
            tmr_ff <= 32'h0;
            longx_ff <= 4'h0;
            steps_ff <= 9'h100 - {1'b0, wait_duration_ff};
            seq_ff <= psc_pkg::SEQ_WAIT;
          end
          else
            seq_ff <= psc_pkg::SEQ_START;
        psc_pkg::SEQ_WAIT:
          if (tmr_ff == 32'(STEP_CYCLES - 1))
          begin
            tmr_ff <= 32'h0;
            if (config_ff[psc_pkg::BIT_LONG_WAIT] && longx_ff != 4'(psc_pkg::LONG_FACTOR - 1))
              longx_ff <= longx_ff + 4'h1;
            else
            begin
              longx_ff <= 4'h0;
              steps_ff <= steps_ff - 9'h1;
              if (steps_ff == 9'h1)
                seq_ff <= psc_pkg::SEQ_WDELAY;
            end
          end
          else
            tmr_ff <= tmr_ff + 32'h1;
        psc_pkg::SEQ_WDELAY:
          if (tmr_ff == 32'(STEP_CYCLES - 1))
            seq_ff <= psc_pkg::SEQ_START;
          else
            tmr_ff <= tmr_ff + 32'h1;
        default: seq_ff <= psc_pkg::SEQ_SLEEP;
      endcase
    end
  end

  // Result latch, threshold and persistence filter
  logic conv_end, out_of_range;
  assign conv_end = seq_ff == psc_pkg::SEQ_CONV && adc_done;
  assign out_of_range = adc_value > lim_ff.high || adc_value < lim_ff.low;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      result_ff <= 16'h0000;
      prox_valid_ff <= 1'b0;
      event_persistence_cnt_ff <= 4'h0;
      irq_pend_ff <= 1'b0;
    end
    else
    begin
      if (conv_end)
      begin
        result_ff <= adc_value;
        prox_valid_ff <= 1'b1;
        if (!out_of_range)
          event_persistence_cnt_ff <= 4'h0;
        else if (event_persistence_cnt_ff != 4'hF)
          event_persistence_cnt_ff <= event_persistence_cnt_ff + 4'h1;
      end
      // Set beats clear in the same cycle
      if (conv_end && out_of_range && {1'b0, event_persistence_cnt_ff} + 5'h01 >= {1'b0, event_persistence_ff[3:0]})
        irq_pend_ff <= 1'b1;
      else if (sf_clear)
        irq_pend_ff <= 1'b0;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      irq_n <= 1'b1;
    else
      irq_n <= ~(irq_pend_ff & enable_ff[psc_pkg::BIT_IRQ_MASK]);
  end
endmodule
`default_nettype wire

// ==== logic/psc_pkg.sv ====
// Constants and types for the proximity sensor controller
`default_nettype none
package psc_pkg;
  localparam logic [6:0] ADDR_VARIANT_A = 7'h39;
  localparam logic [6:0] ADDR_VARIANT_B = 7'h29;
  localparam logic [4:0] REG_ENABLE = 5'h00;
  localparam logic [4:0] REG_INTEG_TIME = 5'h02;
  localparam logic [4:0] REG_WAIT_TIME = 5'h03;
  localparam logic [4:0] REG_LOW_L = 5'h08;
  localparam logic [4:0] REG_LOW_H = 5'h09;
  localparam logic [4:0] REG_HIGH_L = 5'h0A;
  localparam logic [4:0] REG_HIGH_H = 5'h0B;
  localparam logic [4:0] REG_PERSIST = 5'h0C;
  localparam logic [4:0] REG_CONFIG = 5'h0D;
  localparam logic [4:0] REG_PULSE = 5'h0E;
  localparam logic [4:0] REG_CONTROL = 5'h0F;
  localparam logic [4:0] REG_ID = 5'h12;
  localparam logic [4:0] REG_STATUS = 5'h13;
  localparam logic [4:0] REG_RES_L = 5'h18;
  localparam logic [4:0] REG_RES_H = 5'h19;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TIME = 8'hFF;
  localparam int BIT_POWER_ON = 0;
  localparam int BIT_WEN = 3;
  localparam int BIT_IRQ_MASK = 5;
  localparam int BIT_LONG_WAIT = 1;
  localparam logic [1:0] TYPE_REPEAT = 2'b00;
  localparam logic [1:0] TYPE_INCR = 2'b01;
  localparam logic [1:0] TYPE_SPECIAL = 2'b11;
  localparam logic [4:0] SF_IRQ_CLEAR = 5'h05;
  localparam int CLK_NS = 40;
  localparam int STEP_NS = 2720000;
  localparam int PULSE_NS = 16000;
  localparam int STEP_CYC = STEP_NS / CLK_NS;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;
  localparam int LONG_FACTOR = 12;
  typedef enum logic [7:0] {
    SEQ_SLEEP = 8'h01,
    SEQ_SDELAY = 8'h02,
    SEQ_START = 8'h04,
    SEQ_ACCUM = 8'h08,
    SEQ_CONV = 8'h10,
    SEQ_WCHECK = 8'h20,
    SEQ_WAIT = 8'h40,
    SEQ_WDELAY = 8'h80
  } psc_seq_e;
  typedef enum logic [5:0] {
    BUS_IDLE = 6'h01,
    BUS_ADDR = 6'h02,
    BUS_AACK = 6'h04,
    BUS_WBYTE = 6'h08,
    BUS_RBYTE = 6'h10,
    BUS_WACK = 6'h20
  } psc_bus_e;
  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
  } psc_limits_s;
endpackage
`default_nettype wire

// ==== sim/psc_top_assertions.sv ====
// Port-level assertions for the proximity sensor controller
`timescale 1ns/10ps
`default_nettype none
module psc_top_assertions #(
  parameter int PULSE_CYCLES = 8
) (
  input wire logic mclk, // Core clock
  input wire logic sys_rst, // Sync reset
  input wire logic scl_in, // Bus clock
  input wire logic sda_out, // Data drive value
  input wire logic sda_oe, // Data drive enable
  input wire logic irq_n, // Interrupt
  input wire logic led_pulse, // LED pulse
  input wire logic [1:0] led_current_select, // Sink level
  input wire logic adc_start // Conversion start
);
  logic [15:0] hi_ff;
  logic [15:0] lo_ff;
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !led_pulse)
      hi_ff <= 16'h0000;
    else
      hi_ff <= hi_ff + 16'h0001;
  end
  // Saturates so long sleeps cannot wrap into a false short gap
  always_ff @(posedge mclk)
  begin
    if (sys_rst || led_pulse)
      lo_ff <= 16'h0000;
    else if (lo_ff != 16'hFFFF)
      lo_ff <= lo_ff + 16'h0001;
  end
  a_drive_low: assert property (@(posedge mclk) disable iff (sys_rst) sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_rst_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> irq_n && !sda_oe && !led_pulse && !adc_start)
    else $error("outputs active out of reset");
  a_adc_spacing: assert property (@(posedge mclk) disable iff (sys_rst)
    adc_start |=> !adc_start [*8])
    else $error("conversion starts too close");
  a_adc_no_led: assert property (@(posedge mclk) disable iff (sys_rst) adc_start |-> !led_pulse)
    else $error("conversion start during LED pulse");
  a_pulse_high: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(led_pulse) |-> hi_ff == PULSE_CYCLES / 2)
    else $error("LED pulse width wrong");
  a_pulse_gap: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(led_pulse) |-> lo_ff >= PULSE_CYCLES / 2)
    else $error("LED pulse gap too short");
  a_ack_scl_low: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(sda_oe) |-> !scl_in)
    else $error("data line changed with clock high");
  a_sel_scl_low: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(led_current_select) |-> !scl_in)
    else $error("register update outside clock low");
endmodule
bind psc_top psc_top_assertions #(.PULSE_CYCLES(PULSE_CYCLES)) psc_top_assertions_i (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .irq_n(irq_n),
  .led_pulse(led_pulse),
  .led_current_select(led_current_select),
  .adc_start(adc_start)
);
`default_nettype wire

// ==== sim/psc_host.sv ====
// Bus master model standing in for the host processor
`timescale 1ns/10ps
`default_nettype none
module psc_host (
  output logic scl, // Bus clock, idles high
  output logic sda_oe, // High while pulling data low
  input wire logic sda // Resolved data wire
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Long low wait lets a slave ack release before the clock rises
  task automatic start();
    sda_oe = 1'b0;
    #200;
    scl = 1'b1;
    #160;
    sda_oe = 1'b1;
    #160;
    scl = 1'b0;
  endtask
  task automatic stop();
    #40;
    sda_oe = 1'b1;
    #160;
    scl = 1'b1;
    #160;
    sda_oe = 1'b0;
    #160;
  endtask
  // Eight bits then the ack slot; data only moves while the clock is low
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      #40;
      sda_oe = !d[i];
      #160;
      scl = 1'b1;
      #60;
      q[i] = sda;
      #60;
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the proximity sensor controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
  $display("unexpected %s: expected %h seen %h", n, e, s); end end
module tb;
  localparam logic [6:0] ADR = psc_pkg::ADDR_VARIANT_A;
  localparam int STEP = 50;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic adc_done = 1'b0;
  logic [15:0] lvl = 16'h0000;
  logic scl, h_oe, sda_out, sda_oe, irq_n, led_pulse, adc_start;
  logic [1:0] cur_sel;
  logic [1:0] pd_sel;
  wire logic sda_w;
  int miscompares = 0;
  int tests_run = 0;
  int np = 0;
  assign sda_w = !(h_oe || sda_oe);
  always #20 mclk = !mclk;
  psc_host psc_host_i (.scl(scl), .sda_oe(h_oe), .sda(sda_w));
  psc_top #(.STEP_CYCLES(STEP), .PULSE_CYCLES(8)) psc_top_i (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .scl_in(scl),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .irq_n(irq_n),
    .led_pulse(led_pulse),
    .led_current_select(cur_sel),
    .photodiode_select(pd_sel),
    .adc_start(adc_start),
    .adc_done(adc_done),
    .adc_value(lvl)
  );
  // Converter answers a fixed five cycles after its start
  always @(posedge mclk)
  begin
    if (adc_start)
    begin
      repeat (5) @(posedge mclk);
      #1 adc_done = 1'b1;
      @(posedge mclk);
      #1 adc_done = 1'b0;
    end
  end
  always @(posedge led_pulse) np++;
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
    logic [8:0] q;
    psc_host_i.start();
    psc_host_i.xfer({ADR, 1'b0, 1'b1}, q);
    psc_host_i.xfer({c, 1'b1}, q);
    for (int i = 0; i < n; i++) psc_host_i.xfer({d[8*i +: 8], 1'b1}, q);
    psc_host_i.stop();
  endtask
  // Command byte with top bit clear means a plain read
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    logic [8:0] q;
    psc_host_i.start();
    if (c[7])
    begin
      psc_host_i.xfer({ADR, 1'b0, 1'b1}, q);
      psc_host_i.xfer({c, 1'b1}, q);
      psc_host_i.start();
    end
    psc_host_i.xfer({ADR, 1'b1, 1'b1}, q);
    psc_host_i.xfer(9'h1FE, q);
    v[7:0] = q[8:1];
    psc_host_i.xfer(9'h1FF, q);
    v[15:8] = q[8:1];
    psc_host_i.stop();
  endtask
  task automatic conv(output int c);
    c = 0;
    do
    begin
      @(posedge mclk);
      #1;
      c++;
    end
    while (adc_start !== 1'b1 && c < 3000);
    `CHK("conversion start", 1'b1, adc_start)
  endtask
  task automatic t_regs();
    logic [15:0] v;
    rd(8'hA2, v);
    `CHK("timing regs", 16'hFFFF, v)
    rd(8'h80, v);
    `CHK("enable reg", 16'h0000, v)
    wr(8'hA8, 16'h0010, 2);
    wr(8'hAA, 16'h0100, 2);
    rd(8'hA8, v);
    `CHK("lower limit", 16'h0010, v)
    rd(8'hAA, v);
    `CHK("upper limit", 16'h0100, v)
    wr(8'h8E, 16'h0302, 2);
    rd(8'h8E, v);
    `CHK("repeat write", 16'h0303, v)
    rd(8'h00, v);
    `CHK("plain read", 16'h0303, v)
    wr(8'h02, 16'h0000, 0);
    rd(8'h00, v);
    `CHK("held address", 16'h0202, v)
    wr(8'h93, 16'h00FF, 1);
    rd(8'h93, v);
    `CHK("status", 16'h0000, v)
  endtask
  task automatic t_addr();
    logic [8:0] q;
    psc_host_i.start();
    psc_host_i.xfer({psc_pkg::ADDR_VARIANT_B, 1'b0, 1'b1}, q);
    `CHK("foreign address ack", 1'b1, q[0])
    psc_host_i.stop();
    psc_host_i.start();
    psc_host_i.xfer({ADR, 1'b0, 1'b1}, q);
    `CHK("own address ack", 1'b0, q[0])
    psc_host_i.stop();
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h8F, {8'h00, 2'(i), 2'(3 - i), 4'h0}, 1);
      `CHK("current select", 2'(i), cur_sel)
      `CHK("diode select", 2'(3 - i), pd_sel)
    end
  endtask
  task automatic t_meas();
    int c;
    logic [15:0] v;
    wr(8'h8C, 16'h0002, 1);
    lvl = 16'h0200;
    wr(8'h80, 16'h0027, 1);
    conv(c);
    `CHK("start delay", 1'b1, c > 30)
    np = 0;
    conv(c);
    `CHK("pulses per cycle", 2, np)
    `CHK("single event", 1'b1, irq_n)
    repeat (2) conv(c);
    `CHK("above upper", 1'b0, irq_n)
    rd(8'hB8, v);
    `CHK("result", 16'h0200, v)
    lvl = 16'h0050;
    repeat (2) conv(c);
    `CHK("irq held", 1'b0, irq_n)
    wr(8'hE5, 16'h0000, 0);
    conv(c);
    `CHK("irq cleared", 1'b1, irq_n)
    lvl = 16'h0005;
    wr(8'h80, 16'h0007, 1);
    repeat (3) conv(c);
    `CHK("masked", 1'b1, irq_n)
    wr(8'h80, 16'h0027, 1);
    repeat (3) conv(c);
    `CHK("below lower", 1'b0, irq_n)
    wr(8'h80, 16'h0000, 1);
    repeat (100) @(posedge mclk);
    np = 0;
    repeat (300) @(posedge mclk);
    `CHK("sleep pulses", 0, np)
  endtask
  task automatic t_wait();
    int a;
    int b;
    wr(8'h80, 16'h000F, 1);
    repeat (2) conv(a);
    `CHK("wait present", 1'b1, a > 2 * STEP)
    wr(8'h8D, 16'h0002, 1);
    repeat (2) conv(b);
    `CHK("long wait growth", 11 * STEP, b - a)
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge mclk);
    t_regs();
    t_addr();
    t_ctrl();
    t_meas();
    t_wait();
    conclude();
  end
  // Run needs roughly 10k cycles; 50k marks a hang
  initial
  begin
    #2000000;
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
